// ==== core/wss_cfg.svh ====
// Constants for the waveform sequence slot block
`ifndef WSS_CFG_SVH
`define WSS_CFG_SVH
`define WSS_ADDR_W        8
// Register word indices; the byte address on the bus is index times four
`define WSS_IDX_CTRL      8'h0C
`define WSS_IDX_SLOT1     8'h0F
`define WSS_IDX_SLOT2     8'h10
`define WSS_IDX_SLOT3     8'h11
`define WSS_IDX_SLOT8     8'h16
`define WSS_IDX_STATUS    8'h20
`define WSS_NUM_SLOTS     8
// Field positions
`define WSS_SLOT_DLY_BIT  7
`define WSS_CTRL_GO_BIT   0
`define WSS_CTRL_ABORT_BIT 1
// Reset values
`define WSS_SLOT1_RST     8'h01
`define WSS_SLOT_RST      8'h00
// Timing
`define WSS_CLK_MHZ       250
`define WSS_STEP_MS       10
`define WSS_STEP_CYC      (`WSS_STEP_MS * 1000 * `WSS_CLK_MHZ)
`endif

// ==== core/wss_pkg.sv ====
// Types for the waveform sequence slot block
package wss_pkg;
   typedef enum logic [1:0] {
      WSS_IDLE,
      WSS_FETCH,
      WSS_PLAY,
      WSS_WAIT
   } wss_state_e;

   // One sequencer slot: delay select plus seven-bit entry
   typedef struct packed {
      logic       delay_select;
      logic [6:0] entry;
   } wss_slot_s;

   // Request to the drive engine
   typedef struct packed {
      logic       valid;
      logic [6:0] index;
   } wss_play_s;
endpackage

// ==== core/wss_tick.sv ====
// Ten millisecond tick generator
`timescale 1ns/1ps
`include "wss_cfg.svh"
module wss_tick #(
   parameter int unsigned STEP_CYC = `WSS_STEP_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Control
   input  wire logic run_i,
   output logic      tick_o
);
   import wss_pkg::*;

   logic [31:0] cnt;
   logic [31:0] next_cnt;

   // Restart at each run so the first step is a full 10 ms
   always_comb begin
      next_cnt = cnt;
      if (!run_i) begin
         next_cnt = 32'h0;
      end else if (cnt == STEP_CYC - 1) begin
         next_cnt = 32'h0;
      end else begin
         next_cnt = cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt <= 32'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign tick_o = run_i && (cnt == STEP_CYC - 1);
endmodule

// ==== core/wss_delay.sv ====
// Delay slot down-counter in 10 ms steps
`timescale 1ns/1ps
module wss_delay (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Control
   input  wire logic       load_i,
   input  wire logic [6:0] steps_i,
   input  wire logic       tick_i,
   input  wire logic       abort_i,
   // Status
   output logic            busy_o
);
   import wss_pkg::*;

   logic [6:0] left;
   logic [6:0] next_left;

   // Load from the field, count down on ticks
   always_comb begin
      next_left = left;
      if (abort_i) begin
         next_left = 7'h00;
      end else if (load_i) begin
         next_left = steps_i;
      end else if (tick_i && left != 7'h00) begin
         next_left = left - 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         left <= 7'h00;
      end else begin
         left <= next_left;
      end
   end

   assign busy_o = (left != 7'h00);
endmodule

// ==== core/wss_top.sv ====
// Waveform sequencer with slot registers on an Avalon-MM slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "wss_cfg.svh"
module wss_top #(
   parameter int unsigned STEP_CYC = `WSS_STEP_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Drive engine
   output wss_pkg::wss_play_s play_o,
   input  wire logic        play_done_i,
   // Sequencer status
   output logic             busy_o
);
   import wss_pkg::*;

   wss_slot_s  slots [`WSS_NUM_SLOTS];
   wss_slot_s  next_slots [`WSS_NUM_SLOTS];
   wss_state_e state;
   wss_state_e next_state;
   logic [2:0] ptr;
   logic [2:0] next_ptr;
   wss_play_s  next_play;
   logic [31:0] next_rdata;
   logic       ack;
   logic       next_ack;
   logic [7:0] idx;
   logic       wr;
   logic       rd;
   logic       go;
   logic       abort;
   logic       tick;
   logic       dly_load;
   logic       dly_busy;
   logic       dly_load_q;
   wss_slot_s  cur;

   // Word index from byte address
   assign idx = avs_address_i[9:2];
   // One wait state per access: request stands, answer on next edge
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
   // Write lands only at the edge where waitrequest is already low
   assign wr    = avs_write_i && ack && avs_byteenable_i[0];
   assign rd    = avs_read_i && !ack;
   assign go    = wr && idx == `WSS_IDX_CTRL && avs_writedata_i[`WSS_CTRL_GO_BIT];
   assign abort = wr && idx == `WSS_IDX_CTRL && avs_writedata_i[`WSS_CTRL_ABORT_BIT];
   assign cur   = slots[ptr];

   // Slot register writes, one generate per slot
   for (genvar g = 0; g < `WSS_NUM_SLOTS; g++) begin : g_slot
      always_comb begin
         next_slots[g] = slots[g];
         if (wr && idx == `WSS_IDX_SLOT1 + 8'(g)) begin
            next_slots[g] = wss_slot_s'(avs_writedata_i[7:0]);
         end
      end
      always_ff @(posedge clk_i) begin
         if (!rst_b_i) begin
            slots[g] <= (g == 0) ? wss_slot_s'(`WSS_SLOT1_RST)
                                 : wss_slot_s'(`WSS_SLOT_RST);
         end else begin
            slots[g] <= next_slots[g];
         end
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      next_ack   = rd || (avs_write_i && !ack);
      next_rdata = avs_readdata_o;
      if (rd) begin
         next_rdata = 32'h0;
         if (idx >= `WSS_IDX_SLOT1 && idx <= `WSS_IDX_SLOT8) begin
            next_rdata = {24'h0, slots[3'(idx - `WSS_IDX_SLOT1)]};
         end else if (idx == `WSS_IDX_CTRL) begin
            next_rdata = {31'h0, busy_o};
         end else if (idx == `WSS_IDX_STATUS) begin
            next_rdata = {28'h0, busy_o, ptr};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         ack            <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else begin
         ack            <= next_ack;
         avs_readdata_o <= next_rdata;
      end
   end

   // Sequencer: walk slots in address order
   always_comb begin
      next_state = state;
      next_ptr   = ptr;
      next_play  = '0;
      dly_load   = 1'b0;
      unique case (state)
         WSS_IDLE: begin
            if (go) begin
               next_ptr   = 3'h0;
               next_state = WSS_FETCH;
            end
         end
         WSS_FETCH: begin
            if (cur.delay_select) begin
               dly_load   = 1'b1;
               next_state = WSS_WAIT;
            end else if (cur.entry == 7'h00) begin
               next_state = WSS_IDLE;
            end else begin
               next_play.valid = 1'b1;
               next_play.index = cur.entry;
               next_state      = WSS_PLAY;
            end
         end
         WSS_PLAY, WSS_WAIT: begin
            if ((state == WSS_PLAY && play_done_i) || (state == WSS_WAIT && !dly_busy
                && !dly_load_q)) begin
               if (ptr == 3'(`WSS_NUM_SLOTS - 1)) begin
                  next_state = WSS_IDLE;
               end else begin
                  next_ptr   = ptr + 3'h1;
                  next_state = WSS_FETCH;
               end
            end
         end
      endcase
      if (abort) begin
         next_state = WSS_IDLE;
         next_play  = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state      <= WSS_IDLE;
         ptr        <= 3'h0;
         play_o     <= '0;
         dly_load_q <= 1'b0;
      end else begin
         state      <= next_state;
         ptr        <= next_ptr;
         play_o     <= next_play;
         dly_load_q <= dly_load;
      end
   end

   assign busy_o = (state != WSS_IDLE);

   wss_tick #(
      .STEP_CYC(STEP_CYC)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_b_i(rst_b_i),
      .run_i  (state == WSS_WAIT),
      .tick_o (tick)
   );

   wss_delay u_delay (
      .clk_i  (clk_i),
      .rst_b_i(rst_b_i),
      .load_i (dly_load),
      .steps_i(cur.entry),
      .tick_i (tick),
      .abort_i(abort),
      .busy_o (dly_busy)
   );
endmodule

// ==== tb/wss_checker.sv ====
// Bus and sequencer checks for the slot block
`timescale 1ns/1ps
module wss_checker (
   // Clock and reset
   input wire logic               clk_i,
   input wire logic               rst_b_i,
   // Bus and engine
   input wire logic [9:0]         avs_address_i,
   input wire logic               avs_read_i,
   input wire logic               avs_write_i,
   input wire logic [31:0]        avs_writedata_i,
   input wire logic [3:0]         avs_byteenable_i,
   input wire logic [31:0]        avs_readdata_o,
   input wire logic               avs_waitrequest_o,
   input wire wss_pkg::wss_play_s play_o,
   input wire logic               busy_o
);
   import wss_pkg::*;

   logic ctrl_wr;
   logic go_wr;
   logic abort_wr;

   // Accepted control write, split into start and abort
   assign ctrl_wr  = avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h030
                     && avs_byteenable_i[0];
   assign go_wr    = ctrl_wr && avs_writedata_i[1:0] == 2'h1;
   assign abort_wr = ctrl_wr && avs_writedata_i[1];

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Exactly one wait state, never a stall when idle
   wait_state_a: assert property ($rose(avs_read_i | avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state wrong");
   idle_no_wait_a: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
      else $error("stall without request");
   // Read data may only move on a read
   read_hold_a: assert property ((!avs_read_i ##1 !avs_read_i) |-> $stable(avs_readdata_o))
      else $error("read data moved");
   play_pulse_a: assert property (play_o.valid |=> !play_o.valid)
      else $error("play request too long");
   play_busy_a: assert property (play_o.valid |-> busy_o)
      else $error("play while idle");
   zero_play_a: assert property (play_o.valid |-> play_o.index != 7'h00)
      else $error("zero identifier played");
   // Start bit write must wake the sequencer quickly
   go_start_a: assert property (go_wr |-> ##[1:3] busy_o)
      else $error("start ignored");
   // Abort must stop the sequencer at once
   abort_stop_a: assert property (abort_wr |=> !busy_o)
      else $error("abort ignored");
endmodule

bind wss_top wss_checker chk_u (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the slot block
`timescale 1ns/1ps
module tb;
   import wss_pkg::*;
   localparam int S = 8; // Short step keeps delay slots cheap
   // Drive and observe
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [9:0]  avs_address_i = 10'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0]  avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   wss_play_s   play_o;
   logic        play_done_i = 1'b0;
   logic        busy_o;
   logic [31:0] rd;
   int          miscompares = 0;
   int          checked = 0;
   int          c;

   wss_top #(.STEP_CYC(S)) dut_u (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .play_o(play_o), .play_done_i(play_done_i), .busy_o(busy_o));

   always #2 clk_i = ~clk_i;

   task finish_test;
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // One access, held until waitrequest is low at a rising edge
   task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_writedata_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         finish_test;
      end
   endtask

   // Await a play request, check the index, then answer done
   task play(input logic [6:0] id);
      c = 0;
      do begin
         @(negedge clk_i);
         c++;
      end while (play_o.valid !== 1'b1 && c < 500);
      if (c >= 500) begin
         miscompares++;
         finish_test;
      end
      chk({25'h0, play_o.index}, {25'h0, id});
      @(posedge clk_i);
      play_done_i <= 1'b1;
      @(posedge clk_i);
      play_done_i <= 1'b0;
   endtask

   task idle;
      c = 0;
      do begin
         @(negedge clk_i);
         c++;
      end while (busy_o !== 1'b0 && c < 20);
      chk({31'h0, busy_o}, 32'h0);
      if (c >= 20) finish_test;
   endtask

   // Slot reset values, read-back, write without low lane ignored
   task regs_test;
      acc(1'b0, 10'h03C, 8'h00);
      chk(rd, 32'h1);
      acc(1'b0, 10'h040, 8'h00);
      chk(rd, 32'h0);
      acc(1'b0, 10'h044, 8'h00);
      chk(rd, 32'h0);
      acc(1'b1, 10'h040, 8'hA5);
      acc(1'b1, 10'h044, 8'h5A);
      acc(1'b0, 10'h044, 8'h00);
      chk(rd, 32'h5A);
      avs_byteenable_i <= 4'hE;
      acc(1'b1, 10'h040, 8'h00);
      avs_byteenable_i <= 4'hF;
      acc(1'b0, 10'h040, 8'h00);
      chk(rd, 32'hA5);
   endtask

   // Play, delay of three steps, play, then stop at a zero slot
   task delay_test;
      acc(1'b1, 10'h03C, 8'h05);
      acc(1'b1, 10'h040, 8'h83);
      acc(1'b1, 10'h044, 8'h07);
      acc(1'b1, 10'h048, 8'h00);
      acc(1'b1, 10'h030, 8'h01);
      play(7'h05);
      play(7'h07);
      chk({31'h0, c >= 3 * S && c <= 3 * S + 8}, 32'h1);
      idle;
   endtask

   // Eight nonzero slots: the run ends after the last one
   task full_test;
      for (int i = 0; i < 8; i++) acc(1'b1, 10'h03C + 10'(4 * i), 8'(i + 1));
      acc(1'b1, 10'h030, 8'h01);
      for (int i = 0; i < 8; i++) play(7'(i + 1));
      idle;
   endtask

   // Long delay slot: status and control show the run, abort ends it
   task abort_test;
      acc(1'b1, 10'h03C, 8'h85);
      acc(1'b1, 10'h030, 8'h01);
      acc(1'b0, 10'h080, 8'h00);
      chk(rd, 32'h8);
      acc(1'b0, 10'h030, 8'h00);
      chk(rd, 32'h1);
      acc(1'b1, 10'h030, 8'h02);
      idle;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      regs_test;
      delay_test;
      full_test;
      abort_test;
      finish_test;
   end
endmodule
